// ---- inc/fbs_pkg.sv ----
// constants and types shared by the fieldbus slave i/o staging core
// assumes a single 50 MHz clock domain and no software-visible registers
`default_nettype none
package fbs_pkg;
    // sizes of the assembly
    localparam int FBS_VALVES = 32;
    localparam int FBS_MODS = 10;
    localparam int FBS_MOD_W = 16;
    localparam int FBS_DIAG_BYTES = 7;
    // product identification, value is arbitrary
    localparam logic [15:0] FBS_IDENT_DEF = 16'h5A3C;
    // service port addresses
    localparam logic [3:0] FBS_SVC_FSMODE = 4'h0;
    localparam logic [3:0] FBS_SVC_FORCE_OUT = 4'h1;
    localparam logic [3:0] FBS_SVC_FORCE_IN = 4'h2;
    localparam logic [3:0] FBS_SVC_STATUS = 4'h3;
    localparam logic [3:0] FBS_SVC_INP0 = 4'h4;
    // zero output length marks the fail-safe frame
    localparam logic [7:0] FBS_FS_LEN = 8'h00;
    // fail-safe output behaviour while idling
    typedef enum logic [1:0] {FBS_FS_HOLD, FBS_FS_CLEAR, FBS_FS_ON} fbs_fs_mode_t;
    localparam fbs_fs_mode_t FBS_FS_MODE_RST = FBS_FS_CLEAR;
    // exchange state
    typedef enum logic {FBS_ST_RUN, FBS_ST_IDLE} fbs_state_t;
endpackage : fbs_pkg
`default_nettype wire

// ---- inc/fbs_stage_if.sv ----
// signals between the slave core and its output staging stage
// assumes both ends run on the same clock
`default_nettype none
interface fbs_stage_if;
    import fbs_pkg::*;
    logic load;
    logic [31:0] data;
    logic idle;
    fbs_fs_mode_t fs_mode;
    logic sync_on;
    logic sync_pulse;
    logic [31:0] force_on;
    logic [31:0] valve;
    modport ctrl (output load, data, idle, fs_mode, sync_on, sync_pulse, force_on, input valve);
    modport stage (input load, data, idle, fs_mode, sync_on, sync_pulse, force_on, output valve);
endinterface : fbs_stage_if
`default_nettype wire

// ---- design/fbs_out_stage.sv ----
// valve output staging: sync holding, fail-safe state and forcing
// assumes control signals arrive from the core on the same clock
`default_nettype none
module fbs_out_stage
    import fbs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // core side
    fbs_stage_if.stage st
);
    logic [31:0] held_q, held_d;
    logic [31:0] base_q, base_d;
    logic [31:0] valve_q;

    // data waiting for the next sync command
    assign held_d = st.load ? st.data : held_q;

    // base value of the points before forcing
    always_comb begin
        base_d = base_q;
        if (st.idle) begin
            case (st.fs_mode)
                FBS_FS_CLEAR: base_d = '0;
                FBS_FS_ON: base_d = '1;
                default: base_d = base_q;
            endcase
        end else if (st.sync_on) begin
            if (st.sync_pulse) begin
                base_d = held_d;
            end
        end else if (st.load) begin
            base_d = st.data;
        end
    end

    // registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held_q <= '0;
            base_q <= '0;
            valve_q <= '0;
        end else begin
            held_q <= held_d;
            base_q <= base_d;
            valve_q <= base_d | st.force_on;
        end
    end

    assign st.valve = valve_q;

    fs_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        st.idle && st.fs_mode == FBS_FS_CLEAR && st.force_on == '0 |=> st.valve == '0)
        else $error("clear mode did not zero the valves");
    fs_on_a: assert property (@(posedge clk) disable iff (!rst_b)
        st.idle && st.fs_mode == FBS_FS_ON |=> st.valve == '1)
        else $error("forced-on mode did not set the valves");
    sync_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !st.idle && st.sync_on && !st.sync_pulse |=> $stable(base_q))
        else $error("valves moved under sync without a sync command");
    force_out_a: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> (st.valve & $past(st.force_on)) == $past(st.force_on))
        else $error("forced valve point is not on");
endmodule : fbs_out_stage
`default_nettype wire

// ---- design/fbs_core.sv ----
// fieldbus slave core: cyclic exchange, fail-safe idling, freeze/sync,
// diagnosis block and handheld service port
// assumes frames and commands are decoded upstream into one-cycle strobes
// Function
// - on fail-safe the valves go to the selected hold, clear or forced-on state.
// - after a fail-safe frame the core idles, reports it, and keeps that state applied.
// - a freeze command latches the reported input image at that moment.
// - a sync command moves the held output data onto the valves all at once.
// - a fixed 16-bit product identification number is presented to the master.
// - up to 32 valve points and at most 10 attached modules are served.
// - diagnosis holds the standard block followed by one product-specific byte.
// - over-current from an output or supply short raises a diagnosis flag.
// - the service port writes parameters, reads the valves and all input images, and forces points on.
// - analogue values travel as numeric codes in the output direction only.
`default_nettype none
module fbs_core
    import fbs_pkg::*;
#(
    parameter logic [15:0] IDENT = FBS_IDENT_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // data exchange frame
    input wire logic dx_valid,
    input wire logic [7:0] dx_len,
    input wire logic [31:0] dx_out_data,
    input wire logic [15:0] dx_ana_data,
    // global control commands
    input wire logic gc_freeze,
    input wire logic gc_unfreeze,
    input wire logic gc_sync,
    input wire logic gc_unsync,
    // configuration straps
    input wire logic [6:0] station_addr,
    input wire logic [3:0] module_count,
    // module inputs and short detection
    input wire logic [FBS_MODS-1:0][FBS_MOD_W-1:0] mod_in,
    input wire logic [31:0] short_out,
    input wire logic short_supply,
    // diagnosis
    input wire logic diag_rd,
    output logic [FBS_DIAG_BYTES*8-1:0] diag_q,
    output logic diag_flag_q,
    // service port
    input wire logic svc_wr,
    input wire logic svc_rd,
    input wire logic [3:0] svc_addr,
    input wire logic [31:0] svc_wdata,
    output logic [31:0] svc_rdata_q,
    // outputs to the assembly
    output logic [31:0] valve_out,
    output logic [15:0] ana_out_q,
    output logic [FBS_MODS-1:0][FBS_MOD_W-1:0] in_image_q,
    output logic idle_q,
    output logic [15:0] ident_q
);
    fbs_stage_if st ();
    fbs_state_t state_q, state_d;
    fbs_fs_mode_t fs_mode_q;
    logic freeze_on_q, sync_on_q;
    logic short_out_q, short_sup_q;
    logic [31:0] force_out_q;
    logic [FBS_MODS-1:0] force_in_q;
    logic [FBS_MODS-1:0][FBS_MOD_W-1:0] live_w;
    logic fs_frame_w, run_frame_w, img_load_w;
    logic [3:0] svc_idx_w;
    logic [31:0] svc_sel_w;

    // frame classification
    assign fs_frame_w = dx_valid && dx_len == FBS_FS_LEN;
    assign run_frame_w = dx_valid && dx_len != FBS_FS_LEN;

    // idle state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            FBS_ST_RUN: if (fs_frame_w) state_d = FBS_ST_IDLE;
            FBS_ST_IDLE: if (run_frame_w) state_d = FBS_ST_RUN;
            default: state_d = FBS_ST_RUN;
        endcase
    end

    // live inputs: absent modules read zero, forced modules read all ones
    for (genvar g = 0; g < FBS_MODS; g++) begin : g_live
        assign live_w[g] = force_in_q[g] ? '1 : ((4'(g) < module_count) ? mod_in[g] : '0);
    end

    // image refresh when not frozen, capture on every freeze command
    assign img_load_w = gc_freeze || !freeze_on_q;

    // stage control
    assign st.load = run_frame_w;
    assign st.data = dx_out_data;
    assign st.idle = state_d == FBS_ST_IDLE;
    assign st.fs_mode = fs_mode_q;
    assign st.sync_on = sync_on_q || gc_sync;
    assign st.sync_pulse = gc_sync;
    assign st.force_on = force_out_q;
    assign valve_out = st.valve;

    fbs_out_stage u_stage (
        .clk(clk),
        .rst_b(rst_b),
        .st(st)
    );

    // service read selection
    assign svc_idx_w = svc_addr - FBS_SVC_INP0;
    always_comb begin
        if (svc_addr == FBS_SVC_FSMODE) begin
            svc_sel_w = {30'h0000_0000, fs_mode_q};
        end else if (svc_addr == FBS_SVC_FORCE_OUT) begin
            svc_sel_w = st.valve;
        end else if (svc_addr == FBS_SVC_FORCE_IN) begin
            svc_sel_w = {22'h00_0000, force_in_q};
        end else if (svc_addr == FBS_SVC_STATUS) begin
            svc_sel_w = {28'h000_0000, freeze_on_q, sync_on_q, diag_flag_q, idle_q};
        end else if (svc_addr >= FBS_SVC_INP0 && svc_idx_w < 4'(FBS_MODS)) begin
            svc_sel_w = {16'h0000, in_image_q[svc_idx_w]};
        end else begin
            svc_sel_w = '0;
        end
    end

    // mode and parameter registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= FBS_ST_RUN;
            idle_q <= 1'b0;
            freeze_on_q <= 1'b0;
            sync_on_q <= 1'b0;
            fs_mode_q <= FBS_FS_MODE_RST;
            force_out_q <= '0;
            force_in_q <= '0;
            svc_rdata_q <= '0;
            ident_q <= IDENT;
        end else begin
            state_q <= state_d;
            idle_q <= state_d == FBS_ST_IDLE;
            freeze_on_q <= gc_freeze || (freeze_on_q && !gc_unfreeze);
            sync_on_q <= gc_sync || (sync_on_q && !gc_unsync);
            ident_q <= IDENT;
            if (svc_wr && svc_addr == FBS_SVC_FSMODE) fs_mode_q <= fbs_fs_mode_t'(svc_wdata[1:0]);
            if (svc_wr && svc_addr == FBS_SVC_FORCE_OUT) force_out_q <= svc_wdata;
            if (svc_wr && svc_addr == FBS_SVC_FORCE_IN) force_in_q <= svc_wdata[FBS_MODS-1:0];
            if (svc_rd) svc_rdata_q <= svc_sel_w;
        end
    end

    // input image and analogue output code
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_image_q <= '0;
            ana_out_q <= '0;
        end else begin
            if (img_load_w) in_image_q <= live_w;
            if (run_frame_w) ana_out_q <= dx_ana_data;
        end
    end

    // sticky short flags, a new short beats the read clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            short_out_q <= 1'b0;
            short_sup_q <= 1'b0;
            diag_flag_q <= 1'b0;
            diag_q <= '0;
        end else begin
            short_out_q <= (|short_out) || (short_out_q && !diag_rd);
            short_sup_q <= short_supply || (short_sup_q && !diag_rd);
            diag_flag_q <= (|short_out) || short_supply || ((short_out_q || short_sup_q) && !diag_rd);
            // standard block: status, addr, ident; then product byte
            diag_q <= {5'h00, short_sup_q, short_out_q, 1'b0,
                       ident_q[7:0], ident_q[15:8],
                       1'b0, station_addr,
                       8'h00,
                       2'b00, freeze_on_q, sync_on_q, 4'h4,
                       4'h0, short_out_q || short_sup_q, 3'h0};
        end
    end

    zero_len_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        dx_valid && dx_len == 8'h00 |=> idle_q)
        else $error("zero-length frame did not start idling");
    resume_run_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_q && dx_valid && dx_len != 8'h00 |=> !idle_q ##1 1'b1)
        else $error("data frame did not end idling");
    freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        freeze_on_q && !gc_freeze && !gc_unfreeze |=> $stable(in_image_q))
        else $error("frozen input image changed");
    refresh_live_a: assert property (@(posedge clk) disable iff (!rst_b)
        !freeze_on_q && !gc_freeze ##1 !gc_freeze |-> in_image_q[0] == $past(live_w[0]))
        else $error("input image not refreshed");
    absent_mod_a: assert property (@(posedge clk) disable iff (!rst_b)
        !freeze_on_q && module_count < 4'd10 && !force_in_q[9] |=> in_image_q[9] == 16'h0000)
        else $error("absent module reports data");
    short_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|short_out) |=> diag_flag_q ##1 diag_q[49])
        else $error("short circuit not flagged");
    diag_ident_a: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> diag_q[47:32] == {ident_q[7:0], ident_q[15:8]})
        else $error("diagnosis ident bytes wrong");
    ana_code_a: assert property (@(posedge clk) disable iff (!rst_b)
        dx_valid && dx_len != 8'h00 |=> ana_out_q == $past(dx_ana_data))
        else $error("analogue output code not taken");
endmodule : fbs_core
`default_nettype wire

// ---- bench/fbs_master_model.sv ----
// master side model: issues exchange frames and global control commands
// assumes the bench calls its tasks and that clk is the core clock
`default_nettype none
module fbs_master_model
    import fbs_pkg::*;
#(
    parameter logic [6:0] STATION = 7'h15
) (
    // clock
    input wire logic clk,
    // frames and commands toward the slave
    output logic dx_valid,
    output logic [7:0] dx_len,
    output logic [31:0] dx_out_data,
    output logic [15:0] dx_ana_data,
    output logic gc_freeze,
    output logic gc_unfreeze,
    output logic gc_sync,
    output logic gc_unsync,
    output logic [6:0] station_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus, address set once for the whole network
    initial begin
        dx_valid = 1'b0;
        dx_len = 8'h00;
        dx_out_data = 32'h0000_0000;
        dx_ana_data = 16'h0000;
        {gc_freeze, gc_unfreeze, gc_sync, gc_unsync} = 4'h0;
        station_addr = STATION;
    end

    // one exchange frame; a zero length announces fail-safe
    task automatic frame(input logic [7:0] len, input logic [31:0] data, input logic [15:0] ana);
        @(negedge clk);
        dx_valid = 1'b1;
        dx_len = len;
        dx_out_data = data;
        dx_ana_data = ana;
        @(negedge clk);
        dx_valid = 1'b0;
        // unqualified data and analogue fields never keep their last value
        dx_out_data = ~data;
        dx_ana_data = ~ana;
    endtask : frame

    // one-cycle global control: 0 freeze, 1 unfreeze, 2 sync, 3 unsync
    task automatic command(input int which);
        @(negedge clk);
        {gc_freeze, gc_unfreeze, gc_sync, gc_unsync} = 4'(4'h8 >> which);
        @(negedge clk);
        {gc_freeze, gc_unfreeze, gc_sync, gc_unsync} = 4'h0;
    endtask : command
endmodule : fbs_master_model
`default_nettype wire

// ---- bench/fieldbus_slave_io_staging_tb_top.sv ----
// self-checking bench for the slave core, master model on the frame side
// assumes inputs change at the falling edge and outputs stand once settled
`default_nettype none
module fieldbus_slave_io_staging_tb_top
    import fbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] STN = 7'h2a;
    logic clk = 1'b0, rst_b = 1'b0, dx_valid, gc_freeze, gc_unfreeze, gc_sync, gc_unsync;
    logic [7:0] dx_len;
    logic [31:0] dx_out_data, d, e, f;
    logic [15:0] dx_ana_data, a;
    logic [6:0] station_addr;
    logic [3:0] module_count = 4'ha, svc_addr = 4'h0;
    logic [FBS_MODS-1:0][FBS_MOD_W-1:0] mod_in = '0, snap, in_image_q;
    logic [31:0] short_out = '0, svc_wdata = '0, svc_rdata_q, valve_out;
    logic short_supply = 1'b0, diag_rd = 1'b0, svc_wr = 1'b0, svc_rd = 1'b0, diag_flag_q, idle_q;
    logic [FBS_DIAG_BYTES*8-1:0] diag_q;
    logic [15:0] ana_out_q, ident_q;
    int n_fail = 0, check_count = 0;

    // clock
    initial forever #10 clk = ~clk;

    fbs_master_model #(.STATION(STN)) u_master (.clk(clk), .dx_valid(dx_valid), .dx_len(dx_len),
        .dx_out_data(dx_out_data), .dx_ana_data(dx_ana_data), .gc_freeze(gc_freeze),
        .gc_unfreeze(gc_unfreeze), .gc_sync(gc_sync), .gc_unsync(gc_unsync), .station_addr(station_addr));
    fbs_core u_dut (.clk(clk), .rst_b(rst_b), .dx_valid(dx_valid), .dx_len(dx_len),
        .dx_out_data(dx_out_data), .dx_ana_data(dx_ana_data), .gc_freeze(gc_freeze),
        .gc_unfreeze(gc_unfreeze), .gc_sync(gc_sync), .gc_unsync(gc_unsync), .station_addr(station_addr),
        .module_count(module_count), .mod_in(mod_in), .short_out(short_out), .short_supply(short_supply),
        .diag_rd(diag_rd), .diag_q(diag_q), .diag_flag_q(diag_flag_q), .svc_wr(svc_wr), .svc_rd(svc_rd),
        .svc_addr(svc_addr), .svc_wdata(svc_wdata), .svc_rdata_q(svc_rdata_q), .valve_out(valve_out),
        .ana_out_q(ana_out_q), .in_image_q(in_image_q), .idle_q(idle_q), .ident_q(ident_q));

    // compare and count
    task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // levels stand, so a few cycles let every stage land
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask : settle

    // service port write and read pulses
    task automatic svc(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
        @(negedge clk);
        {svc_wr, svc_rd} = {wr, ~wr};
        svc_addr = adr;
        svc_wdata = wd;
        @(negedge clk);
        {svc_wr, svc_rd} = 2'b00;
        svc_wdata = ~wd;
        settle();
    endtask : svc

    // valve state expected while idling
    function automatic logic [31:0] fs_valve(input int m, input logic [31:0] last);
        return (m == int'(FBS_FS_HOLD)) ? last : (m == int'(FBS_FS_CLEAR)) ? 32'h0000_0000 : 32'hffff_ffff;
    endfunction : fs_valve

    // reported image: forced modules all ones, modules beyond the count read zero
    function automatic logic [FBS_MODS-1:0][FBS_MOD_W-1:0] exp_image(
        input logic [FBS_MODS-1:0][FBS_MOD_W-1:0] live, input int cnt, input logic [FBS_MODS-1:0] frc);
        exp_image = '0;
        for (int i = 0; i < FBS_MODS; i++) begin
            exp_image[i] = frc[i] ? 16'hffff : ((i < cnt) ? live[i] : 16'h0000);
        end
    endfunction : exp_image

    // verdict
    task automatic results();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // watchdog
    initial begin
        #100_000;
        n_fail++;
        results();
    end

    // test sequence
    initial begin
        void'($urandom(32'hd01d_dd10));
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        chk(ident_q, FBS_IDENT_DEF);
        chk(idle_q, 1'b0);
        $display("reset test done");
        repeat (16) begin
            d = $urandom;
            a = 16'($urandom);
            u_master.frame(8'($urandom_range(1, 255)), d, a);
            settle();
            chk(valve_out, d);
            chk(ana_out_q, a);
        end
        $display("exchange test done");
        for (int m = 0; m < 3; m++) begin
            svc(1'b1, FBS_SVC_FSMODE, 32'(m));
            d = $urandom;
            u_master.frame(8'h04, d, a);
            u_master.frame(FBS_FS_LEN, ~d, ~a);
            settle();
            chk(idle_q, 1'b1);
            chk(valve_out, fs_valve(m, d));
            chk(ana_out_q, a);
            svc(1'b0, FBS_SVC_STATUS, 32'h0000_0000);
            chk(svc_rdata_q[0], 1'b1);
            u_master.frame(8'h01, ~d, a);
            settle();
            chk({idle_q, valve_out}, {1'b0, ~d});
        end
        $display("fail-safe test done");
        foreach (mod_in[i]) mod_in[i] = 16'($urandom);
        snap = mod_in;
        settle();
        chk(in_image_q, snap);
        u_master.command(0);
        mod_in = ~snap;
        settle();
        chk(in_image_q, snap);
        chk(diag_q[13:12], 2'b10);
        svc(1'b0, 4'(FBS_SVC_INP0 + 4'h7), 32'h0000_0000);
        chk(svc_rdata_q, {16'h0000, snap[7]});
        u_master.command(1);
        settle();
        chk(in_image_q, ~snap);
        $display("freeze test done");
        d = $urandom;
        e = $urandom;
        u_master.frame(8'h04, d, a);
        u_master.command(2);
        u_master.frame(8'h04, e, a);
        settle();
        chk(valve_out, d);
        u_master.command(2);
        settle();
        chk(valve_out, e);
        u_master.command(3);
        f = $urandom;
        svc(1'b1, FBS_SVC_FORCE_OUT, f);
        chk(valve_out, e | f);
        svc(1'b1, FBS_SVC_FORCE_OUT, 32'h0000_0000);
        $display("sync and force test done");
        @(negedge clk);
        short_out = 32'h0000_0001 << $urandom_range(0, 31);
        short_supply = 1'b1;
        @(negedge clk);
        short_out = '0;
        short_supply = 1'b0;
        settle();
        chk({diag_flag_q, diag_q[50:49]}, 3'b111);
        chk(diag_q[47:24], {FBS_IDENT_DEF[7:0], FBS_IDENT_DEF[15:8], 1'b0, STN});
        @(negedge clk);
        diag_rd = 1'b1;
        @(negedge clk);
        diag_rd = 1'b0;
        settle();
        chk({diag_flag_q, diag_q[50:49]}, 3'b000);
        $display("diagnosis test done");
        module_count = 4'($urandom_range(0, 9));
        f = 32'h0000_0001 << $urandom_range(0, 8);
        svc(1'b1, FBS_SVC_FORCE_IN, f);
        chk(in_image_q, exp_image(mod_in, int'(module_count), f[FBS_MODS-1:0]));
        svc(1'b0, FBS_SVC_FORCE_IN, 32'h0000_0000);
        chk(svc_rdata_q, f);
        svc(1'b0, FBS_SVC_FSMODE, 32'h0000_0000);
        chk(svc_rdata_q, 32'(FBS_FS_ON));
        svc(1'b0, FBS_SVC_FORCE_OUT, 32'h0000_0000);
        chk(svc_rdata_q, e);
        $display("module and service test done");
        results();
    end
endmodule : fieldbus_slave_io_staging_tb_top
`default_nettype wire
